// [verilog/sgr_pkg.sv]
// What this block does
// - any finger count, up to ten tracked contacts
// - run when enabled, report when output enabled
// - all starting fingers share one edge, corners count
// - no common edge abandons edge detection
// - one finger narrow band, others wide band
// - non-edge start: centre swipe on travel, tolerance
// - edge start: travel inward beyond threshold, in time
// - north/south vertical travel, east/west horizontal only
// - report once all exceed, unless time expired
// - after decision wait for full lift-off
// - time limit counted in 1/156250 s ticks
// - report is id a0, flags, finger count
// - one-hot edge flag, north in lowest bit
// - centre flags in upper nibble, south first
package sgr_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned TICK_HZ = 156250;
	localparam int unsigned TICK_CYC = (CLK_HZ + TICK_HZ - 1) / TICK_HZ;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);

	// ----------------------------------------
	// message encoding
	// ----------------------------------------
	localparam logic [7:0] MSG_SWIPE_ID = 8'ha0;
	localparam int unsigned FLAG_EDGE_LSB = 0;
	localparam int unsigned FLAG_CTR_LSB = 4;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_LAST = 8'h0c;
	localparam logic [7:0] REG_TLIMIT = 8'h10;
	localparam logic [7:0] REG_PARAM0 = 8'h14;
	localparam int unsigned NPARAM = 11;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_OUT_BIT = 1;
	localparam int unsigned ST_EDGE_BIT = 0;
	localparam int unsigned ST_CTR_BIT = 1;
	localparam int unsigned ST_TMO_BIT = 2;
	localparam int unsigned P_EDGE_THR = 0;
	localparam int unsigned P_NB_L = 1;
	localparam int unsigned P_NB_R = 2;
	localparam int unsigned P_NB_T = 3;
	localparam int unsigned P_NB_B = 4;
	localparam int unsigned P_WB_L = 5;
	localparam int unsigned P_WB_R = 6;
	localparam int unsigned P_WB_T = 7;
	localparam int unsigned P_WB_B = 8;
	localparam int unsigned P_CTR_THR = 9;
	localparam int unsigned P_CTR_TOL = 10;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [31:0] TLIMIT_RST = 32'h0003_9387;
	localparam logic [NPARAM-1:0][15:0] PARAM_RST = {
		16'h0200, 16'h0400, 16'h1e00, 16'h0600, 16'h0d9c, 16'h0600,
		16'h2100, 16'h0300, 16'h1100, 16'h0300, 16'h0400};

	typedef enum logic [1:0] {
		SGR_IDLE = 2'b00,
		SGR_EDGE = 2'b01,
		SGR_CENTRE = 2'b10,
		SGR_DONE = 2'b11
	} sgr_state_t;

endpackage

// [verilog/sgr_cfg_if.sv]
`timescale 1ns/10ps
interface sgr_cfg_if;
	logic enable;
	logic out_en;
	logic [31:0] time_limit;
	logic [sgr_pkg::NPARAM-1:0][15:0] param;
	logic ev_edge;
	logic ev_centre;
	logic ev_timeout;
	logic [7:0] last_flags;
	logic [7:0] last_fingers;
	logic [1:0] core_state;

	modport regs (
		output enable, out_en, time_limit, param,
		input ev_edge, ev_centre, ev_timeout, last_flags, last_fingers, core_state
	);
	modport core (
		input enable, out_en, time_limit, param,
		output ev_edge, ev_centre, ev_timeout, last_flags, last_fingers, core_state
	);
endinterface

// [verilog/sgr_regs.sv]
`timescale 1ns/10ps
module sgr_regs (
	input wire logic clk, // 200 MHz clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // write byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq, // level interrupt
	sgr_cfg_if.regs cfg // to recogniser
);

	typedef struct packed {
		logic wait_q;
		logic [31:0] rdata;
		logic [1:0] ctrl;
		logic [2:0] status;
		logic [2:0] mask;
		logic irq;
		logic [31:0] tlimit;
		logic [sgr_pkg::NPARAM-1:0][15:0] param;
	} sgr_regs_st_t;

	sgr_regs_st_t s_q;
	sgr_regs_st_t s_d;

	// merge write data into a word by byte lane
	function automatic logic [31:0] sgr_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// bus slave, sticky status, interrupt
	// ----------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic [31:0] wv;
		logic [5:0] pidx;
		logic [2:0] ev;
		logic acc;
		rd = 32'h0;
		wv = 32'h0;
		ev = {cfg.ev_timeout, cfg.ev_centre, cfg.ev_edge};
		acc = (avs_read | avs_write) & ~s_q.wait_q;
		pidx = 6'(avs_address[7:2] - sgr_pkg::REG_PARAM0[7:2]);
		s_d = s_q;
		// one wait state, then one cycle with waitrequest low
		s_d.wait_q = ~((avs_read | avs_write) & s_q.wait_q);
		case (avs_address)
			sgr_pkg::REG_CTRL: rd = {30'h0, s_q.ctrl};
			sgr_pkg::REG_STATUS: rd = {29'h0, s_q.status};
			sgr_pkg::REG_MASK: rd = {29'h0, s_q.mask};
			sgr_pkg::REG_LAST: rd = {14'h0, cfg.core_state, cfg.last_fingers, cfg.last_flags};
			sgr_pkg::REG_TLIMIT: rd = s_q.tlimit;
			default: begin
				if (avs_address[1:0] == 2'h0 && avs_address >= sgr_pkg::REG_PARAM0 &&
						pidx < 6'(sgr_pkg::NPARAM)) begin
					rd = {16'h0, s_q.param[pidx[3:0]]};
				end
			end
		endcase
		if (avs_read & s_q.wait_q) begin
			s_d.rdata = rd;
		end
		// events set status; a set wins over a same-cycle clear
		s_d.status = s_q.status | ev;
		if (acc & avs_write) begin
			wv = sgr_merge(rd, avs_writedata, avs_byteenable);
			case (avs_address)
				sgr_pkg::REG_CTRL: s_d.ctrl = wv[1:0];
				sgr_pkg::REG_STATUS: begin
					// ones on an enabled lane clear; untouched lanes leave flags alone
					s_d.status = (s_q.status & ~(avs_writedata[2:0] & {3{avs_byteenable[0]}})) | ev;
				end
				sgr_pkg::REG_MASK: s_d.mask = wv[2:0];
				sgr_pkg::REG_TLIMIT: s_d.tlimit = wv;
				default: begin
					if (avs_address[1:0] == 2'h0 && avs_address >= sgr_pkg::REG_PARAM0 &&
							pidx < 6'(sgr_pkg::NPARAM)) begin
						s_d.param[pidx[3:0]] = wv[15:0];
					end
				end
			endcase
		end
		s_d.irq = |(s_d.status & s_d.mask);
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{wait_q: 1'b1, rdata: 32'h0, ctrl: sgr_pkg::CTRL_RST, status: 3'h0,
				mask: 3'h0, irq: 1'b0, tlimit: sgr_pkg::TLIMIT_RST, param: sgr_pkg::PARAM_RST};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs and configuration
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_q;
	assign irq = s_q.irq;
	assign cfg.enable = s_q.ctrl[sgr_pkg::CTRL_EN_BIT];
	assign cfg.out_en = s_q.ctrl[sgr_pkg::CTRL_OUT_BIT];
	assign cfg.time_limit = s_q.tlimit;
	assign cfg.param = s_q.param;

endmodule // sgr_regs

// [verilog/sgr_swipe.sv]
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module sgr_swipe #(
	parameter int unsigned NC = 10 // tracked contacts
) (
	input wire logic clk, // 200 MHz clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // write byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq, // level interrupt
	input wire logic frame_valid, // one-cycle: contacts below are a complete frame
	input wire logic [NC-1:0] contact_down, // contact slot is touching
	input wire logic [NC-1:0][15:0] contact_x, // raw x per slot
	input wire logic [NC-1:0][15:0] contact_y, // raw y per slot
	output logic msg_valid, // one-cycle report strobe
	output logic [7:0] msg_id, // report identifier
	output logic [7:0] msg_flags, // swipe flag mask
	output logic [7:0] msg_fingers // fingers that took part
);

	// all recogniser state in one record; start positions are frozen at touch-down, so
	// travel is always measured from where each finger landed, never frame to frame
	typedef struct packed {
		sgr_pkg::sgr_state_t state;
		logic [3:0] edge_sel;
		logic [10:0] presc;
		logic [31:0] ticks;
		logic [NC-1:0] start_mask;
		logic [NC-1:0][15:0] start_x;
		logic [NC-1:0][15:0] start_y;
		logic msg_valid;
		logic [7:0] msg_id;
		logic [7:0] msg_flags;
		logic [7:0] msg_fingers;
		logic ev_edge;
		logic ev_centre;
		logic ev_timeout;
	} sgr_core_t;

	sgr_core_t s_q;
	sgr_core_t s_d;

	// configuration and status travel between the two halves in one bundle
	sgr_cfg_if cfg ();

	// ----------------------------------------
	// register file
	// ----------------------------------------
	// bus slave, sticky status and parameter words; the recogniser only reads them
	sgr_regs sgr_regs_inst (
		.clk(clk),
		.rstn(rstn),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.irq(irq),
		.cfg(cfg)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// signed travel from start to now on one raw axis
	// one extra bit keeps a full-scale move from wrapping
	function automatic logic signed [16:0] sgr_gain(input logic [15:0] now, input logic [15:0] st);
		return $signed({1'b0, now}) - $signed({1'b0, st});
	endfunction

	// travel strictly beyond a threshold
	// landing exactly on the threshold is not enough
	function automatic logic sgr_over(input logic signed [16:0] v, input logic [15:0] thr);
		return v > $signed({1'b0, thr});
	endfunction

	// magnitude within a tolerance
	// both signs are checked so drift to either side counts
	function automatic logic sgr_within(input logic signed [16:0] v, input logic [15:0] tol);
		return (v <= $signed({1'b0, tol})) && (-v <= $signed({1'b0, tol}));
	endfunction

	// lowest set bit only
	// picks one edge or direction when several qualify, fixed priority
	function automatic logic [3:0] sgr_first(input logic [3:0] v);
		return v & (4'(~v) + 4'h1);
	endfunction

	// number of set slots
	// cannot exceed the slot count, so the byte never overflows
	function automatic logic [7:0] sgr_count(input logic [NC-1:0] v);
		logic [7:0] n;
		n = 8'h0;
		for (int i = 0; i < NC; i++) begin
			n = n + {7'h0, v[i]};
		end
		return n;
	endfunction

	// ----------------------------------------
	// recogniser
	// ----------------------------------------
	always_comb begin
		logic [NC-1:0] live;
		logic [3:0] wide_all;
		logic [3:0] nar_any;
		logic [3:0] trav_all;
		logic [3:0] dir_all;
		logic [3:0] edge_hit;
		logic signed [16:0] dx;
		logic signed [16:0] dy;
		logic [15:0] x;
		logic [15:0] y;
		logic expired;
		logic [sgr_pkg::NPARAM-1:0][15:0] p;
		live = contact_down & s_q.start_mask;
		wide_all = 4'hf;
		nar_any = 4'h0;
		trav_all = 4'hf;
		dir_all = 4'hf;
		dx = 17'sh0;
		dy = 17'sh0;
		x = 16'h0;
		y = 16'h0;
		p = cfg.param;
		// judged only on frames; the tick count itself steps every 1280 cycles while in the edge state
		expired = s_q.ticks >= cfg.time_limit;
		s_d = s_q;
		// strobes and event pulses drop unless a decision is made this frame
		s_d.msg_valid = 1'b0;
		s_d.ev_edge = 1'b0;
		s_d.ev_centre = 1'b0;
		s_d.ev_timeout = 1'b0;

		// per-finger band membership and travel, raw coordinates
		for (int i = 0; i < NC; i++) begin
			x = contact_x[i];
			y = contact_y[i];
			if (contact_down[i]) begin
				// bit order north, east, south, west; a corner sets two bits
				wide_all &= {x < p[sgr_pkg::P_WB_L], y > p[sgr_pkg::P_WB_B],
					x > p[sgr_pkg::P_WB_R], y < p[sgr_pkg::P_WB_T]};
				nar_any |= {x < p[sgr_pkg::P_NB_L], y > p[sgr_pkg::P_NB_B],
					x > p[sgr_pkg::P_NB_R], y < p[sgr_pkg::P_NB_T]};
			end
			// only start fingers still down are judged; late arrivals are ignored
			if (live[i]) begin
				dx = sgr_gain(x, s_q.start_x[i]);
				dy = sgr_gain(y, s_q.start_y[i]);
				// inward travel on the edge's own axis only
				trav_all &= {sgr_over(dx, p[sgr_pkg::P_EDGE_THR]),
					sgr_over(-dy, p[sgr_pkg::P_EDGE_THR]),
					sgr_over(-dx, p[sgr_pkg::P_EDGE_THR]),
					sgr_over(dy, p[sgr_pkg::P_EDGE_THR])};
				// direction with lateral tolerance: east, north, west, south
				dir_all &= {sgr_over(dx, p[sgr_pkg::P_CTR_THR]) & sgr_within(dy, p[sgr_pkg::P_CTR_TOL]),
					sgr_over(-dy, p[sgr_pkg::P_CTR_THR]) & sgr_within(dx, p[sgr_pkg::P_CTR_TOL]),
					sgr_over(-dx, p[sgr_pkg::P_CTR_THR]) & sgr_within(dy, p[sgr_pkg::P_CTR_TOL]),
					sgr_over(dy, p[sgr_pkg::P_CTR_THR]) & sgr_within(dx, p[sgr_pkg::P_CTR_TOL])};
			end
		end
		// an edge needs every finger in its wide band and one in its narrow band
		edge_hit = wide_all & nar_any;

		// tick timebase runs only while an edge swipe is pending
		// the prescaler restarts at touch-down so the first tick is a full period;
		// ticks saturate rather than wrap, so a long hold never looks fresh again
		if (s_q.state == sgr_pkg::SGR_EDGE) begin
			if (s_q.presc == sgr_pkg::TICK_LAST) begin
				s_d.presc = 11'h0;
				if (s_q.ticks != 32'hffff_ffff) begin
					s_d.ticks = s_q.ticks + 32'h1;
				end
			end else begin
				s_d.presc = s_q.presc + 11'h1;
			end
		end

		// disabling drops any half-seen gesture; nothing is reported for it later
		if (!cfg.enable) begin
			s_d.state = sgr_pkg::SGR_IDLE;
		end else if (frame_valid) begin
			case (s_q.state)
				sgr_pkg::SGR_IDLE: begin
					// fresh touch with any number of fingers
					// start positions and the band verdict are latched from this frame
					if (|contact_down) begin
						s_d.start_mask = contact_down;
						s_d.start_x = contact_x;
						s_d.start_y = contact_y;
						s_d.ticks = 32'h0;
						s_d.presc = 11'h0;
						s_d.edge_sel = sgr_first(edge_hit);
						if (|edge_hit) begin
							s_d.state = sgr_pkg::SGR_EDGE;
						end else begin
							s_d.state = sgr_pkg::SGR_CENTRE;
						end
					end
				end
				sgr_pkg::SGR_EDGE: begin
					// expiry is judged before travel, so a late move is never reported;
					// losing every start finger while others touch ends the attempt quietly
					if (!(|contact_down)) begin
						s_d.state = sgr_pkg::SGR_IDLE;
					end else if (!(|live) || expired) begin
						s_d.ev_timeout = expired;
						s_d.state = sgr_pkg::SGR_DONE;
					end else if (|(trav_all & s_q.edge_sel)) begin
						s_d.ev_edge = 1'b1;
						s_d.msg_valid = cfg.out_en;
						s_d.msg_id = sgr_pkg::MSG_SWIPE_ID;
						s_d.msg_flags = {4'h0, s_q.edge_sel};
						s_d.msg_fingers = sgr_count(live);
						s_d.state = sgr_pkg::SGR_DONE;
					end
				end
				sgr_pkg::SGR_CENTRE: begin
					// the first frame where every start finger still down clears the threshold decides;
					// a finger that strays sideways holds the report back
					if (!(|contact_down)) begin
						s_d.state = sgr_pkg::SGR_IDLE;
					end else if (!(|live)) begin
						s_d.state = sgr_pkg::SGR_DONE;
					end else if (|dir_all) begin
						s_d.ev_centre = 1'b1;
						s_d.msg_valid = cfg.out_en;
						s_d.msg_id = sgr_pkg::MSG_SWIPE_ID;
						s_d.msg_flags = {sgr_first(dir_all), 4'h0};
						s_d.msg_fingers = sgr_count(live);
						s_d.state = sgr_pkg::SGR_DONE;
					end
				end
				sgr_pkg::SGR_DONE: begin
					// hold until a frame arrives with the surface fully clear
					if (!(|contact_down)) begin
						s_d.state = sgr_pkg::SGR_IDLE;
					end
				end
				default: s_d.state = sgr_pkg::SGR_IDLE;
			endcase
		end
	end

	// state register; a reset mid-gesture forgets it, the host sees no partial report
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{state: sgr_pkg::SGR_IDLE, edge_sel: 4'h0, presc: 11'h0, ticks: 32'h0,
				start_mask: '0, start_x: '0, start_y: '0, msg_valid: 1'b0, msg_id: 8'h0,
				msg_flags: 8'h0, msg_fingers: 8'h0, ev_edge: 1'b0, ev_centre: 1'b0,
				ev_timeout: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// the last report stays readable after its strobe has gone
	// outputs and status back to the register file
	assign msg_valid = s_q.msg_valid;
	assign msg_id = s_q.msg_id;
	assign msg_flags = s_q.msg_flags;
	assign msg_fingers = s_q.msg_fingers;
	assign cfg.ev_edge = s_q.ev_edge;
	assign cfg.ev_centre = s_q.ev_centre;
	assign cfg.ev_timeout = s_q.ev_timeout;
	assign cfg.last_flags = s_q.msg_flags;
	assign cfg.last_fingers = s_q.msg_fingers;
	assign cfg.core_state = s_q.state;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking sgr_cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// every report carries the swipe identifier
	report_id_a: assert property (msg_valid |-> msg_id == 8'ha0)
		else $error("report id wrong");
	// an edge report names exactly one edge
	edge_flag_one_a: assert property (msg_valid && msg_flags[3:0] != 4'h0 |->
		$onehot(msg_flags))
		else $error("edge flags not one-hot");
	// a centre report names one direction and follows the centre path
	centre_flag_one_a: assert property (msg_valid && msg_flags[7:4] != 4'h0 |->
		$onehot(msg_flags) && $past(s_q.state) == sgr_pkg::SGR_CENTRE)
		else $error("centre flags wrong");
	// nothing reaches the host unless both control bits were set
	report_gate_a: assert property (msg_valid |-> $past(cfg.out_en) && $past(cfg.enable))
		else $error("report while output disabled");
	// decisions are taken on frame edges only
	report_frame_a: assert property (msg_valid |-> $past(frame_valid))
		else $error("report without a frame");
	// an edge report is only issued while the tick count is under the limit
	edge_in_time_a: assert property (msg_valid && msg_flags[3:0] != 4'h0 |->
		$past(s_q.ticks) < $past(cfg.time_limit))
		else $error("edge report after time limit");
	// once decided, the machine holds while anything touches
	done_hold_a: assert property (s_q.state == sgr_pkg::SGR_DONE && cfg.enable &&
		(|contact_down) |=> s_q.state == sgr_pkg::SGR_DONE)
		else $error("left done while touching");
	// a clear frame releases the hold
	release_idle_a: assert property (s_q.state == sgr_pkg::SGR_DONE && cfg.enable &&
		frame_valid && !(|contact_down) |=> s_q.state == sgr_pkg::SGR_IDLE)
		else $error("hold not released on lift-off");
	// a touch leaves idle for the edge or the centre path
	touch_start_a: assert property (s_q.state == sgr_pkg::SGR_IDLE && cfg.enable &&
		frame_valid && (|contact_down) |=>
		s_q.state == sgr_pkg::SGR_EDGE || s_q.state == sgr_pkg::SGR_CENTRE)
		else $error("touch did not start a swipe");
	// disabling forces idle on the next cycle
	disable_idle_a: assert property (!cfg.enable |=> s_q.state == sgr_pkg::SGR_IDLE)
		else $error("running while disabled");
	// the finger count is never zero and never above the slot count
	fingers_range_a: assert property (msg_valid |-> msg_fingers != 8'h0 &&
		msg_fingers <= 8'(NC))
		else $error("finger count out of range");
	// the tick count advances once per prescaler wrap
	tick_step_a: assert property (s_q.state == sgr_pkg::SGR_EDGE && cfg.enable &&
		s_q.presc == sgr_pkg::TICK_LAST && !frame_valid && s_q.ticks != 32'hffff_ffff
		|=> s_q.ticks == $past(s_q.ticks) + 32'h1)
		else $error("tick did not advance");
	// a timed-out attempt stays silent
	timeout_quiet_a: assert property (s_q.ev_timeout |-> !msg_valid)
		else $error("report after edge timeout");
	// a report is a single-cycle strobe
	report_pulse_a: assert property (msg_valid |=> !msg_valid)
		else $error("report strobe too long");

	// main scenarios
	edge_swipe_c: cover property (msg_valid && msg_flags[3:0] != 4'h0);
	centre_swipe_c: cover property (msg_valid && msg_flags[7:4] != 4'h0);
	edge_timeout_c: cover property (s_q.ev_timeout);
	multi_finger_c: cover property (msg_valid && msg_fingers > 8'h01);
	quiet_swipe_c: cover property (s_q.ev_centre && !msg_valid);

endmodule // sgr_swipe

// [bench/sgr_host.sv]
`timescale 1ns/10ps
// ----------------------------------------
// host side: collects swipe reports
// ----------------------------------------
module sgr_host (
	input wire logic clk, // 200 MHz clock
	input wire logic rstn, // async reset, active low
	input wire logic msg_valid, // report strobe
	input wire logic [7:0] msg_id, // report identifier
	input wire logic [7:0] msg_flags, // swipe flag mask
	input wire logic [7:0] msg_fingers, // finger count
	output logic [15:0] rx_count, // reports taken so far
	output logic [7:0] rx_id, // identifier of last report
	output logic [7:0] rx_flags, // flags of last report
	output logic [7:0] rx_fingers // fingers of last report
);
	// take one report per strobe, the whole message in one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_count <= 16'h0000;
			rx_id <= 8'h00;
			rx_flags <= 8'h00;
			rx_fingers <= 8'h00;
		end else if (msg_valid === 1'b1) begin
			rx_count <= rx_count + 16'h0001;
			rx_id <= msg_id;
			rx_flags <= msg_flags;
			rx_fingers <= msg_fingers;
		end
	end
endmodule // sgr_host

// [bench/sgr_swipe_tb.sv]
`timescale 1ns/10ps
module sgr_swipe_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic frame_valid = 1'b0;
	logic [9:0] contact_down = 10'h000;
	logic [9:0][15:0] contact_x = '0;
	logic [9:0][15:0] contact_y = '0;
	logic msg_valid;
	logic [7:0] msg_id;
	logic [7:0] msg_flags;
	logic [7:0] msg_fingers;
	logic [15:0] rx_count;
	logic [7:0] rx_id;
	logic [7:0] rx_flags;
	logic [7:0] rx_fingers;
	logic [15:0] exp_cnt = 16'h0000;
	logic [31:0] rd = 32'h0;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	// one-finger swipe table: edges n e s w, then centre s w n e
	logic [15:0] sx[8] = '{16'h07d0, 16'h1194, 16'h07d0, 16'h0064,
		16'h09c4, 16'h09c4, 16'h09c4, 16'h09c4};
	logic [15:0] sy[8] = '{16'h0064, 16'h0fa0, 16'h2198, 16'h0fa0,
		16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0fa0};
	logic [15:0] dx[8] = '{16'h0, 16'hfbb4, 16'h0, 16'h044c, 16'h0, 16'hfbb4, 16'h0, 16'h044c};
	logic [15:0] dy[8] = '{16'h044c, 16'h0, 16'hfbb4, 16'h0, 16'h044c, 16'h0, 16'hfbb4, 16'h0};
	logic [7:0] fl[8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	sgr_swipe #(.NC(10)) sgr_swipe_inst (.clk(clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .frame_valid(frame_valid),
		.contact_down(contact_down), .contact_x(contact_x), .contact_y(contact_y),
		.msg_valid(msg_valid), .msg_id(msg_id), .msg_flags(msg_flags),
		.msg_fingers(msg_fingers));

	sgr_host sgr_host_inst (.clk(clk), .rstn(rstn), .msg_valid(msg_valid), .msg_id(msg_id),
		.msg_flags(msg_flags), .msg_fingers(msg_fingers), .rx_count(rx_count),
		.rx_id(rx_id), .rx_flags(rx_flags), .rx_fingers(rx_fingers));

	// verdict and end of run
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches++;
			finish_test();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one bus access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rd = avs_readdata;
		if (n >= 100)
			mismatches++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(rd, exp, what);
	endtask

	// irq is registered from the next status and mask, so it changes in the same cycle as them
	task irqchk(input logic exp);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, {31'h0, exp}, "irq");
	endtask

	// one completed frame with up to two fingers
	task frame(input logic [9:0] d, input logic [15:0] ax, ay, bx, by);
		@(posedge clk);
		frame_valid <= 1'b1;
		contact_down <= d;
		contact_x[0] <= ax;
		contact_y[0] <= ay;
		contact_x[1] <= bx;
		contact_y[1] <= by;
		@(posedge clk);
		frame_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// touch, move all fingers by the same step, check report, lift off
	task gest(input logic [9:0] d, input logic [15:0] ax, ay, bx, by, mx, my,
		input logic [7:0] f, input logic hit, input string what);
		frame(d, ax, ay, bx, by);
		frame(d, ax + mx, ay + my, bx + mx, by + my);
		if (hit)
			exp_cnt++;
		check(rx_count, exp_cnt, what);
		if (hit) begin
			check(rx_flags, f, what);
			check(rx_fingers, 8'($countones(d)), what);
			check(rx_id, 8'ha0, what);
		end
		frame(10'h000, 16'h0, 16'h0, 16'h0, 16'h0);
		$display("test %s done", what);
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		// reset values and an unmapped word
		rdchk(8'h00, 32'h0, "ctrl reset");
		rdchk(8'h08, 32'h0, "mask reset");
		rdchk(8'h10, 32'h0003_9387, "limit reset");
		rdchk(8'h14, 32'h400, "edge travel reset");
		rdchk(8'h18, 32'h300, "narrow left reset");
		rdchk(8'h3c, 32'h200, "tolerance reset");
		bus(1'b1, 8'h80, 32'hffff_ffff);
		rdchk(8'h80, 32'h0, "unmapped");
		bus(1'b1, 8'h10, 32'h4);
		bus(1'b1, 8'h08, 32'h7);
		bus(1'b1, 8'h00, 32'h3);
		$display("test registers done");
		// travel threshold boundary, then hold after the decision
		frame(10'h001, 16'h07d0, 16'h0064, 16'h0, 16'h0);
		frame(10'h001, 16'h07d0, 16'h0464, 16'h0, 16'h0);
		check(rx_count, exp_cnt, "exact threshold");
		frame(10'h001, 16'h07d0, 16'h0465, 16'h0, 16'h0);
		exp_cnt++;
		check(rx_count, exp_cnt, "past threshold");
		rdchk(8'h0c, 32'h0003_0101, "last after report");
		frame(10'h001, 16'h07d0, 16'h09c4, 16'h0, 16'h0);
		check(rx_count, exp_cnt, "held after report");
		irqchk(1'b1);
		rdchk(8'h04, 32'h1, "edge status");
		bus(1'b1, 8'h08, 32'h0);
		irqchk(1'b0);
		bus(1'b1, 8'h08, 32'h7);
		irqchk(1'b1);
		bus(1'b1, 8'h04, 32'h7);
		irqchk(1'b0);
		frame(10'h000, 16'h0, 16'h0, 16'h0, 16'h0);
		$display("test boundary done");
		for (int i = 0; i < 8; i++)
			gest(10'h001, sx[i], sy[i], 16'h0, 16'h0, dx[i], dy[i], fl[i], 1'b1, "table");
		gest(10'h003, 16'h0064, 16'h0064, 16'h07d0, 16'h03e8, 16'h0, 16'h044c, 8'h01, 1'b1,
			"corner");
		gest(10'h003, 16'h07d0, 16'h0064, 16'h07d0, 16'h2198, 16'h0, 16'h044c, 8'h10, 1'b1,
			"mixed edges");
		gest(10'h001, 16'h09c4, 16'h0fa0, 16'h0, 16'h0, 16'h0200, 16'h044c, 8'h10, 1'b1,
			"lateral limit");
		gest(10'h001, 16'h09c4, 16'h0fa0, 16'h0, 16'h0, 16'h0258, 16'h044c, 8'h0, 1'b0,
			"lateral over");
		gest(10'h001, 16'h07d0, 16'h03e8, 16'h0, 16'h0, 16'h0, 16'h044c, 8'h10, 1'b1,
			"wide band only");
		gest(10'h001, 16'h07d0, 16'h0064, 16'h0, 16'h0, 16'h044c, 16'h0, 8'h0, 1'b0,
			"sideways");
		// edge start, then move after the time limit of 4 ticks
		bus(1'b1, 8'h04, 32'h7);
		frame(10'h001, 16'h07d0, 16'h0064, 16'h0, 16'h0);
		repeat (6000) @(posedge clk);
		frame(10'h001, 16'h07d0, 16'h0514, 16'h0, 16'h0);
		check(rx_count, exp_cnt, "late move");
		rdchk(8'h04, 32'h4, "timeout status");
		frame(10'h000, 16'h0, 16'h0, 16'h0, 16'h0);
		$display("test timeout done");
		// output disabled, then recognition disabled
		bus(1'b1, 8'h04, 32'h7);
		bus(1'b1, 8'h00, 32'h1);
		gest(10'h001, 16'h09c4, 16'h0fa0, 16'h0, 16'h0, 16'h0, 16'h044c, 8'h0, 1'b0, "quiet");
		rdchk(8'h04, 32'h2, "quiet status");
		bus(1'b1, 8'h04, 32'h7);
		bus(1'b1, 8'h00, 32'h0);
		gest(10'h001, 16'h09c4, 16'h0fa0, 16'h0, 16'h0, 16'h0, 16'h044c, 8'h0, 1'b0, "off");
		rdchk(8'h04, 32'h0, "off status");
		finish_test();
	end
endmodule // sgr_swipe_tb
